// ### bench/i2c_target_model.sv
// behavioural I2C target: acks its address and written bytes, sends a counting byte stream
// assumes a pulled-up bus whose clock the host makes; this target never stretches it
`timescale 1ns/100ps
module i2c_target_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50,
  parameter logic [7:0] FIRST_BYTE = 8'h00
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [7:0] sent = 8'h00;
  int bitc = 0;
  logic first = 1'b0;
  logic rd = 1'b0;
  logic sel = 1'b0;
  initial sda_pull = 1'b0;
  always @(negedge sda) if (scl) begin
    bitc = 0;
    first = 1'b1;
  end
  always @(posedge sda) if (scl) begin
    sel = 1'b0;
    sda_pull = 1'b0;
  end
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    bitc++;
  end
  always @(negedge scl) begin
    if (bitc == 8 && first) begin
      sel = sh[7:1] == DEV_ADDR;
      rd = sh[0];
      first = 1'b0;
      sda_pull = sel;
    end else if (bitc == 8) begin
      sda_pull = sel && !rd;
    end else if (bitc == 9) begin
      // a low ninth bit is our address ack or the host's ack: both ask for a byte
      bitc = 0;
      tx = FIRST_BYTE + sent;
      if (sel && rd && !sh[0]) sent++;
      sda_pull = sel && rd && !sh[0] && !tx[7];
    end else begin
      sda_pull = sel && rd && !tx[7 - bitc];
    end
  end
endmodule

// ### bench/sensor_side_i2c_host_asserts.sv
// port assertions of the I2C host
// assumes both clock domains share the asynchronous active-high reset
`timescale 1ns/100ps
module sensor_side_i2c_host_asserts #(
  parameter int QUARTER = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [23:0] reg_rdata,
  input wire logic sample_start,
  input wire logic bypass_en,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic host_busy
);
  localparam int QSPAN = 4 * QUARTER;
  logic en_sh;
  logic pst_sh;
  // the trigger bit clears itself, so only enable and sample-select are mirrored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      en_sh <= 1'b0;
      pst_sh <= 1'b1;
    end else if (reg_wr && reg_addr == 8'h01) begin
      en_sh <= reg_wdata[19];
      pst_sh <= reg_wdata[17];
    end
  end
  AST_SW_TRIG_BUSY: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == 8'h01 && reg_wdata[19:17] == 3'b110 && !bypass_en && !host_busy
    |-> ##[1:4] host_busy) else $error("software trigger started nothing");
  AST_SAMPLE_TRIG_BUSY: assert property (@(posedge clk) disable iff (reset)
    sample_start && en_sh && pst_sh && !bypass_en && !host_busy |-> ##[1:3] host_busy)
    else $error("sample start started nothing");
  AST_WRITE_VISIBLE: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == 8'h02 ##1 reg_addr == 8'h02 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("address register write not read back");
  AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (reset)
    !reg_wr ##1 ($stable(reg_addr) && reg_addr == 8'h05) |=> $stable(reg_rdata))
    else $error("read data moved without a write");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (reset)
    reg_addr == 8'h04 |=> reg_rdata[22:20] == 3'h0) else $error("reserved bits not zero");
  AST_START_THEN_SCL: assert property (@(posedge link_clk) disable iff (reset)
    $rose(sda_oe) && !scl_oe |-> ##[1:QSPAN] scl_oe) else $error("start without clock low");
  AST_SCL_HIGH_MIN: assert property (@(posedge link_clk) disable iff (reset)
    $fell(scl_oe) |-> !scl_oe [*4]) else $error("clock high phase too short");
  AST_SCL_LOW_MIN: assert property (@(posedge link_clk) disable iff (reset)
    $rose(scl_oe) |-> scl_oe [*4]) else $error("clock low phase too short");
  cover property (@(posedge clk) disable iff (reset) sample_start && en_sh && pst_sh);
  cover property (@(posedge clk) disable iff (reset) $fell(host_busy));
  cover property (@(posedge link_clk) disable iff (reset) $rose(sda_oe) && !scl_oe);
endmodule

// ### bench/tb_sensor_side_i2c_host.sv
// register-level bench of the I2C host against an EEPROM and a temperature sensor model
// assumes the design, the target model and the checker are compiled first
`timescale 1ns/100ps
module tb_sensor_side_i2c_host;
  logic clk, link_clk, reset, reg_wr, sample_start, scl_oe, sda_oe, host_busy;
  logic pull_ee, pull_ts;
  logic scl_o, sda_o, onchip_temp_valid = 1'b0, bypass_en = 1'b0, tgt_scl = 1'b1, tgt_sda = 1'b1;
  logic [11:0] onchip_temp_in = 12'h000, onchip_temp_avg;
  logic [7:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata;
  logic [1:0] active_channel;
  logic [23:0] rst_val [7] = '{24'h120140, 24'h92a4c8, 24'h800000, 24'h000017,
    24'h080000, 24'h000000, 24'h000000};
  int err_total = 0;
  int samples_checked = 0;
  // a pin shows the driven level only while its enable is high, else the pull-up
  wire scl_w = scl_o | !scl_oe;
  wire sda_w = (sda_o | !sda_oe) & !(pull_ee | pull_ts);
  sensor_side_i2c_host #(.QUARTER(4)) dut (.clk, .reset, .link_clk, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rdata, .sample_start, .active_channel, .bypass_en,
    .onchip_temp_in, .onchip_temp_valid, .onchip_temp_avg, .scl_i(scl_w),
    .scl_o, .scl_oe, .sda_i(sda_w), .sda_o, .sda_oe, .tgt_scl_i(tgt_scl), .tgt_sda_i(tgt_sda),
    .host_busy);
  i2c_target_model #(.DEV_ADDR(7'h50), .FIRST_BYTE(8'h1c)) eeprom (.scl(scl_w),
    .sda(sda_w), .sda_pull(pull_ee));
  i2c_target_model #(.DEV_ADDR(7'h48), .FIRST_BYTE(8'h3c)) tsens (.scl(scl_w),
    .sda(sda_w), .sda_pull(pull_ts));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  task automatic complete_run();
    $display("mismatches %0d of %0d checks", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] exp);
    @(posedge clk);
    #2 reg_addr = a;
    repeat (2) @(posedge clk);
    #2 check(reg_rdata, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    #2 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #2 reg_wr = 1'b0;
  endtask
  task automatic pulse();
    @(posedge clk);
    #2 sample_start = 1'b1;
    @(posedge clk);
    #2 sample_start = 1'b0;
  endtask
  // a hung sequence ends the run rather than the simulation limit
  task automatic wait_idle();
    int n = 0;
    repeat (4) @(posedge clk);
    while (host_busy !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) begin
      err_total++;
      complete_run();
    end
  endtask
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 24'h000000;
    sample_start = 1'b0;
    active_channel = 2'h0;
    repeat (16) @(posedge clk);
    #2 reset = 1'b0;
    for (int i = 0; i < 7; i++) rd(8'(i + 1), rst_val[i]);
    // on-chip average defaults to four samples: 10h, 20h, 30h, 40h average to 28h
    for (int i = 1; i < 5; i++) begin
      @(posedge clk);
      #2 onchip_temp_in = 12'(i * 16);
      onchip_temp_valid = 1'b1;
    end
    @(posedge clk);
    #2 onchip_temp_valid = 1'b0;
    check(24'(onchip_temp_avg), 24'h000028);
    wait_idle();
    rd(8'h03, 24'h80011c);
    wr(8'h03, 24'h002400);
    wr(8'h07, 24'h050000);
    wr(8'h01, 24'h1a0140);
    pulse();
    wait_idle();
    rd(8'h03, 24'h00251d);
    wr(8'h01, 24'h1c0142);
    wait_idle();
    rd(8'h03, 24'h0025f8);
    rd(8'h01, 24'h180142);
    wr(8'h07, 24'h010000);
    rd(8'h03, 24'h002504);
    wr(8'h03, 24'h022400);
    wr(8'h07, 24'h000000);
    wr(8'h01, 24'h2c0140);
    wait_idle();
    rd(8'h03, 24'h022521);
    wr(8'h01, 24'h180140);
    wr(8'h02, 24'h32a4c8);
    pulse();
    wait_idle();
    rd(8'h04, 24'h03c317);
    wr(8'h04, 24'h800017);
    wr(8'h02, 24'h72a4c8);
    pulse();
    wait_idle();
    rd(8'h04, 24'h83d317);
    bypass_en = 1'b1;
    tgt_scl = 1'b0;
    repeat (3) @(posedge clk);
    #2 check(24'({scl_oe, sda_oe}), 24'h000002);
    complete_run();
  end
endmodule
bind sensor_side_i2c_host sensor_side_i2c_host_asserts #(.QUARTER(QUARTER)) checker_inst (
  .clk, .reset, .link_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .sample_start,
  .bypass_en, .scl_oe, .sda_oe, .host_busy);

// ### hw/host_cfg.svh
// register offsets, field positions, reset values and bus timing of the I2C host
// assumes registers are reached by their printed index on a 24-bit register port
`ifndef HOST_CFG_SVH
`define HOST_CFG_SVH

`define OFS_CTRL 8'h01
`define OFS_TADDR 8'h02
`define OFS_XFER 8'h03
`define OFS_ETEMP 8'h04
`define OFS_CNT2 8'h05
`define OFS_SEL 8'h07

`define RST_CTRL 24'h120140
`define RST_TADDR 24'h92a4c8
`define RST_XFER 24'h800000
`define RST_ETEMP 24'h000017
`define RST_CNT2 24'h080000
`define RST_SEL 24'h000000

`define WM_CTRL 24'h3e01fe
`define WM_TADDR 24'hffffff
`define WM_XFER 24'hc3fe00
`define WM_ETEMP 24'h8000ff
`define WM_CNT2 24'hff0000
`define WM_SEL 24'hff00ff

`define C1_RW_HI 21
`define C1_RW_LO 20
`define C1_EN 19
`define C1_TRIG 18
`define C1_PST 17
`define C1_EEA_HI 8
`define C1_EEA_LO 2
`define C1_SWAP 1
`define C2_TAVG_HI 23
`define C2_TAVG_LO 22
`define C2_TREN 21
`define C2_TA2_HI 20
`define C2_TA2_LO 14
`define C2_TA1_HI 13
`define C2_TA1_LO 7
`define C2_TA0_HI 6
`define C2_TA0_LO 0
`define C3_OAVG_HI 23
`define C3_OAVG_LO 22
`define C3_NTRAN 17
`define C3_PTR_HI 16
`define C3_PTR_LO 9
`define C4_UNS 23
`define C5_CNT2_LO 22
`define C7_SEL_HI 19
`define C7_SEL_LO 18
`define C7_CNT1_LO 16
`define C7_WD2_HI 7
`define C7_WD2_LO 0

`define LINK_CLK_KHZ 83333
`define SCL_KHZ 100
`define SCL_QUARTER ((`LINK_CLK_KHZ + 4 * `SCL_KHZ - 1) / (4 * `SCL_KHZ))

`endif

// ### hw/host_link_if.sv
// command link between the sequencer (clk domain) and the bit engine (link_clk)
// assumes toggle handshake: command fields stay stable while req_tgl != done_tgl
`timescale 1ns/100ps
interface host_link_if;
  logic req_tgl;
  host_pkg::bus_cmd_t cmd;
  logic [7:0] wbyte;
  logic mack;
  logic bypass;
  logic done_tgl;
  logic [7:0] rbyte;
  logic nack;
  modport ctl(output req_tgl, cmd, wbyte, mack, bypass, input done_tgl, rbyte, nack);
  modport eng(input req_tgl, cmd, wbyte, mack, bypass, output done_tgl, rbyte, nack);
endinterface

// ### hw/host_pkg.sv
// types shared by the I2C host sequencer, its bit engine and their link
// assumes host_cfg.svh supplies all numeric constants
package host_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_START = 8'h02, ST_ADDR = 8'h04, ST_WDATA = 8'h08,
    ST_RSTART = 8'h10, ST_RADDR = 8'h20, ST_RDATA = 8'h40, ST_STOP = 8'h80
  } seq_state_t;
  typedef enum logic [1:0] {
    JOB_BOOT = 2'h0, JOB_GEN1 = 2'h1, JOB_GEN2 = 2'h2, JOB_TEMP = 2'h3
  } job_t;
  typedef enum logic [2:0] {
    CMD_START = 3'h0, CMD_STOP = 3'h1, CMD_RSTART = 3'h2, CMD_WRITE = 3'h3, CMD_READ = 3'h4
  } bus_cmd_t;
  typedef enum logic [1:0] {E_IDLE = 2'h1, E_RUN = 2'h2} eng_state_t;
endpackage

// ### hw/i2c_bit_engine.sv
// open-drain I2C bit engine on link_clk: START, STOP, repeated START, byte write/read
// assumes commands arrive over host_link_if with a toggle handshake from another clock
`timescale 1ns/100ps
`include "host_cfg.svh"
module i2c_bit_engine #(
  parameter int QUARTER = `SCL_QUARTER
) (
  input wire logic link_clk,
  input wire logic reset,
  host_link_if.eng link,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic tgt_scl_i,
  input wire logic tgt_sda_i,
  output logic scl_oe,
  output logic sda_oe
);
  typedef struct packed {
    host_pkg::eng_state_t est;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [11:0] cnt;
    logic [7:0] sh, rbyte;
    logic nack, scl_oe, sda_oe, done_tgl, seen;
    logic req_s1, req_s2, scl_s1, scl_s2, sda_s1, sda_s2;
    logic tscl_s1, tscl_s2, tsda_s1, tsda_s2, byp_s1, byp_s2;
  } eng_t;
  eng_t s, n;
  logic last;

  always_comb begin
    n = s;
    last = 1'b0;
    n.req_s1 = link.req_tgl;
    n.req_s2 = s.req_s1;
    n.scl_s1 = scl_i;
    n.scl_s2 = s.scl_s1;
    n.sda_s1 = sda_i;
    n.sda_s2 = s.sda_s1;
    n.tscl_s1 = tgt_scl_i;
    n.tscl_s2 = s.tscl_s1;
    n.tsda_s1 = tgt_sda_i;
    n.tsda_s2 = s.tsda_s1;
    n.byp_s1 = link.bypass;
    n.byp_s2 = s.byp_s1;
    case (s.est)
      host_pkg::E_IDLE: begin
        // one-way follow of the target bus; a two-way copy through flops would latch low
        if (s.byp_s2) begin
          n.scl_oe = ~s.tscl_s2;
          n.sda_oe = ~s.tsda_s2;
        end
        if (s.req_s2 != s.seen) begin
          n.seen = s.req_s2;
          n.est = host_pkg::E_RUN;
          n.q = 2'h0;
          n.bitn = 4'h0;
          n.cnt = 12'(QUARTER - 1);
          n.sh = link.wbyte;
        end
      end
      host_pkg::E_RUN: begin
        if (s.cnt != 12'h000) begin
          n.cnt = s.cnt - 12'h001;
        end else begin
          n.cnt = 12'(QUARTER - 1);
          n.q = s.q + 2'h1;
          case (link.cmd)
            host_pkg::CMD_START: begin
              if (s.q == 2'h0) n.sda_oe = 1'b1;
              else begin
                n.scl_oe = 1'b1;
                last = 1'b1;
              end
            end
            host_pkg::CMD_STOP: begin
              if (s.q == 2'h0) n.sda_oe = 1'b1;
              else if (s.q == 2'h1) n.scl_oe = 1'b0;
              else begin
                n.sda_oe = 1'b0;
                last = 1'b1;
              end
            end
            host_pkg::CMD_RSTART: begin
              if (s.q == 2'h0) n.sda_oe = 1'b0;
              else if (s.q == 2'h1) n.scl_oe = 1'b0;
              else if (s.q == 2'h2) n.sda_oe = 1'b1;
              else begin
                n.scl_oe = 1'b1;
                last = 1'b1;
              end
            end
            default: begin
              case (s.q)
                2'h0: begin
                  if (s.bitn != 4'h8) begin
                    n.sda_oe = (link.cmd == host_pkg::CMD_WRITE) ? ~s.sh[7] : 1'b0;
                  end else begin
                    n.sda_oe = (link.cmd == host_pkg::CMD_READ) ? link.mack : 1'b0; // R21
                  end
                end
                2'h1: n.scl_oe = 1'b0;
                2'h2: begin
                  // a target holding SCL low stretches the low phase
                  if (!s.scl_s2) begin
                    n.q = s.q;
                    n.cnt = 12'h000;
                  end else if (s.bitn != 4'h8) begin
                    n.sh = {s.sh[6:0], s.sda_s2};
                  end else begin
                    n.nack = s.sda_s2;
                  end
                end
                default: begin
                  n.scl_oe = 1'b1;
                  n.bitn = s.bitn + 4'h1;
                  if (s.bitn == 4'h8) last = 1'b1;
                end
              endcase
            end
          endcase
          if (last) begin
            n.rbyte = s.sh;
            n.est = host_pkg::E_IDLE;
            n.done_tgl = ~s.done_tgl;
          end
        end
      end
      default: n.est = host_pkg::E_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.est <= host_pkg::E_IDLE;
    end else begin
      s <= n;
    end
  end

  assign link.done_tgl = s.done_tgl;
  assign link.rbyte = s.rbyte;
  assign link.nack = s.nack;
  assign scl_oe = s.scl_oe;
  assign sda_oe = s.sda_oe;
endmodule

// ### hw/sensor_side_i2c_host.sv
// register-controlled I2C host: EEPROM boot read, generic transactions, temperature reads
// assumes reg_* and sample_start are on clk; the I2C pins are handled on link_clk
`timescale 1ns/100ps
`include "host_cfg.svh"
//
// Operation
// R1 - direction field: low bit first transaction, high bit second; 1 read, 0 write
// R2 - per-sample select set: every sample start launches the generic sequence
// R3 - software trigger bit launches the sequence when per-sample mode is off
// R4 - EEPROM target address is a programmable seven-bit field, default 50h
// R5 - swap control reverses bit order of every received byte
// R6 - external temperature averaged over none, 2 or 4 samples, default 4
// R7 - read enable makes each sample start read the active channel's sensor
// R8 - three sensor target addresses, defaults 48h, 49h and 4Ah
// R9 - on-chip temperature averaged over none, 2 or 4 samples; code 3 invalid
// R10 - transaction-count bit: 0 one transaction, 1 two transactions
// R11 - eight-bit field holds the target register address sent before reads
// R12 - status bit reads 1 once the EEPROM boot load has completed
// R13 - read-only field shows a selected byte of received data
// R14 - unsigned-format bit makes external temperature unsigned, else signed
// R15 - external temperature value reads at bits 19 to 8
// R16 - software keeps 17h in the low reserved byte of that register
// R17 - second transaction byte count: 0 one byte, 1 two bytes
// R18 - first transaction byte count: 0 one byte, 1 two bytes
// R19 - selector picks which byte of the 32-bit read result is shown
// R20 - bypass disables the host and joins host bus to target bus
// R21 - read: START, address+W, register, repeated START, address+R, ack all but last
// R22 - software trigger clears itself once its sequence has finished
module sensor_side_i2c_host #(
  parameter int QUARTER = `SCL_QUARTER
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  output logic [23:0] reg_rdata,
  input wire logic sample_start,
  input wire logic [1:0] active_channel,
  input wire logic bypass_en,
  input wire logic [11:0] onchip_temp_in,
  input wire logic onchip_temp_valid,
  output logic [11:0] onchip_temp_avg,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic tgt_scl_i,
  input wire logic tgt_sda_i,
  output logic host_busy
);
  typedef struct packed {
    logic [23:0] r1, r2, r3, r4, r5, r7, rdata;
    host_pkg::seq_state_t st;
    host_pkg::job_t job;
    logic idx, issued, err;
    logic [31:0] result;
    logic boot_pend, gen_pend, temp_pend, soft_run, load_done;
    logic req_tgl;
    host_pkg::bus_cmd_t cmd;
    logic [7:0] wbyte;
    logic mack, bypass, done_s1, done_s2, temp_valid;
    logic [11:0] temp_sample;
    logic busy;
  } host_state_t;
  host_state_t s, n;

  host_link_if link();
  logic [11:0] ext_avg;
  logic host_en, rd, nb, ptr, done_hit, fin_gen;
  logic [6:0] addr7;
  logic [7:0] sel_byte, rx;
  host_pkg::bus_cmd_t want_cmd;
  logic [7:0] want_byte;
  logic want_mack;

  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = b[7-i];
    return r;
  endfunction

  always_comb begin
    n = s;
    n.temp_valid = 1'b0;
    n.done_s1 = link.done_tgl;
    n.done_s2 = s.done_s1;
    n.bypass = bypass_en;
    fin_gen = 1'b0;
    host_en = s.r1[`C1_EN] & ~bypass_en; // R20
    // per-job transfer shape
    rd = 1'b1;
    nb = 1'b0;
    ptr = 1'b1;
    addr7 = s.r1[`C1_EEA_HI:`C1_EEA_LO]; // R4
    case (s.job)
      host_pkg::JOB_GEN1: begin
        rd = s.r1[`C1_RW_LO]; // R1
        nb = s.r7[`C7_CNT1_LO]; // R18
      end
      host_pkg::JOB_GEN2: begin
        rd = s.r1[`C1_RW_HI]; // R1
        nb = s.r5[`C5_CNT2_LO]; // R17
      end
      host_pkg::JOB_TEMP: begin
        nb = 1'b1;
        ptr = 1'b0;
        case (active_channel) // R8
          2'h0: addr7 = s.r2[`C2_TA0_HI:`C2_TA0_LO];
          2'h1: addr7 = s.r2[`C2_TA1_HI:`C2_TA1_LO];
          default: addr7 = s.r2[`C2_TA2_HI:`C2_TA2_LO];
        endcase
      end
      default: ;
    endcase
    rx = s.r1[`C1_SWAP] ? rev8(link.rbyte) : link.rbyte; // R5
    // command for the current step
    want_cmd = host_pkg::CMD_WRITE;
    want_byte = 8'h00;
    want_mack = 1'b0;
    case (s.st)
      host_pkg::ST_START: want_cmd = host_pkg::CMD_START;
      host_pkg::ST_ADDR: want_byte = {addr7, rd & ~ptr};
      host_pkg::ST_WDATA: begin
        if (s.idx) want_byte = s.r7[`C7_WD2_HI:`C7_WD2_LO];
        else if (s.job != host_pkg::JOB_BOOT) want_byte = s.r3[`C3_PTR_HI:`C3_PTR_LO]; // R11
      end
      host_pkg::ST_RSTART: want_cmd = host_pkg::CMD_RSTART; // R21
      host_pkg::ST_RADDR: want_byte = {addr7, 1'b1}; // R21
      host_pkg::ST_RDATA: begin
        want_cmd = host_pkg::CMD_READ;
        want_mack = (s.idx != nb); // R21
      end
      host_pkg::ST_STOP: want_cmd = host_pkg::CMD_STOP;
      default: ;
    endcase
    if (s.st != host_pkg::ST_IDLE && !s.issued) begin
      n.issued = 1'b1;
      n.req_tgl = ~s.req_tgl;
      n.cmd = want_cmd;
      n.wbyte = want_byte;
      n.mack = want_mack;
    end
    done_hit = s.issued && (s.done_s2 == s.req_tgl);
    if (done_hit) begin
      n.issued = 1'b0;
      case (s.st)
        host_pkg::ST_START: n.st = host_pkg::ST_ADDR;
        host_pkg::ST_ADDR: begin
          if (link.nack) begin
            n.err = 1'b1;
            n.st = host_pkg::ST_STOP;
          end else begin
            n.st = (rd & ~ptr) ? host_pkg::ST_RDATA : host_pkg::ST_WDATA;
          end
        end
        host_pkg::ST_WDATA: begin
          if (link.nack) begin
            n.err = 1'b1;
            n.st = host_pkg::ST_STOP;
          end else if (rd) begin
            n.st = host_pkg::ST_RSTART; // R21
          end else if (s.idx == nb) begin
            n.st = host_pkg::ST_STOP;
          end else begin
            n.idx = 1'b1;
          end
        end
        host_pkg::ST_RSTART: n.st = host_pkg::ST_RADDR;
        host_pkg::ST_RADDR: begin
          n.idx = 1'b0;
          if (link.nack) begin
            n.err = 1'b1;
            n.st = host_pkg::ST_STOP;
          end else begin
            n.st = host_pkg::ST_RDATA;
          end
        end
        host_pkg::ST_RDATA: begin
          n.result = {s.result[23:0], rx};
          if (s.idx == nb) n.st = host_pkg::ST_STOP;
          else n.idx = 1'b1;
        end
        host_pkg::ST_STOP: begin
          n.st = host_pkg::ST_IDLE;
          case (s.job)
            host_pkg::JOB_BOOT: begin
              n.boot_pend = 1'b0;
              n.load_done = ~s.err; // R12
            end
            host_pkg::JOB_GEN1: begin
              if (s.r3[`C3_NTRAN] && !s.err) begin // R10
                n.job = host_pkg::JOB_GEN2;
                n.st = host_pkg::ST_START;
                n.idx = 1'b0;
              end else begin
                fin_gen = 1'b1;
              end
            end
            host_pkg::JOB_GEN2: fin_gen = 1'b1;
            default: begin
              n.temp_pend = 1'b0;
              if (!s.err) begin
                n.temp_valid = 1'b1;
                n.temp_sample = s.result[15:4];
              end
            end
          endcase
        end
        default: n.st = host_pkg::ST_IDLE;
      endcase
    end
    if (fin_gen) begin
      n.gen_pend = 1'b0;
      if (s.soft_run) begin
        n.soft_run = 1'b0;
        n.r1[`C1_TRIG] = 1'b0; // R22
      end
    end
    // triggers come after the clears so a coincident event is kept
    if (host_en && s.r1[`C1_PST] && sample_start) n.gen_pend = 1'b1; // R2
    if (host_en && !s.r1[`C1_PST] && s.r1[`C1_TRIG] && !s.soft_run) begin // R3
      n.gen_pend = 1'b1;
      n.soft_run = 1'b1;
    end
    if (host_en && s.r2[`C2_TREN] && sample_start) n.temp_pend = 1'b1; // R7
    if (s.st == host_pkg::ST_IDLE && !s.issued) begin
      if (s.boot_pend) begin
        n.job = host_pkg::JOB_BOOT;
        n.st = host_pkg::ST_START;
      end else if (s.gen_pend && host_en) begin
        n.job = host_pkg::JOB_GEN1;
        n.st = host_pkg::ST_START;
      end else if (s.temp_pend && host_en) begin
        n.job = host_pkg::JOB_TEMP;
        n.st = host_pkg::ST_START;
      end
      if (n.st != host_pkg::ST_IDLE) begin
        n.idx = 1'b0;
        n.err = 1'b0;
        n.result = 32'h00000000;
      end
    end
    // software writes land last, so a written value beats an internal clear
    if (reg_wr) begin
      case (reg_addr)
        `OFS_CTRL: n.r1 = reg_wdata & `WM_CTRL;
        `OFS_TADDR: n.r2 = reg_wdata & `WM_TADDR;
        `OFS_XFER: n.r3 = reg_wdata & `WM_XFER;
        `OFS_ETEMP: n.r4 = reg_wdata & `WM_ETEMP; // R16
        `OFS_CNT2: n.r5 = reg_wdata & `WM_CNT2;
        `OFS_SEL: n.r7 = reg_wdata & `WM_SEL;
        default: ;
      endcase
    end
    case (s.r7[`C7_SEL_HI:`C7_SEL_LO]) // R19
      2'h0: sel_byte = s.result[7:0];
      2'h1: sel_byte = s.result[15:8];
      2'h2: sel_byte = s.result[23:16];
      default: sel_byte = s.result[31:24];
    endcase
    case (reg_addr)
      `OFS_CTRL: n.rdata = s.r1;
      `OFS_TADDR: n.rdata = s.r2;
      `OFS_XFER: n.rdata = s.r3 | {15'h0000, s.load_done, sel_byte}; // R13
      `OFS_ETEMP: n.rdata = s.r4 | {4'h0, ext_avg, 8'h00}; // R15
      `OFS_CNT2: n.rdata = s.r5;
      `OFS_SEL: n.rdata = s.r7;
      default: n.rdata = 24'h000000;
    endcase
    n.busy = (n.st != host_pkg::ST_IDLE);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.r1 <= `RST_CTRL;
      s.r2 <= `RST_TADDR;
      s.r3 <= `RST_XFER;
      s.r4 <= `RST_ETEMP;
      s.r5 <= `RST_CNT2;
      s.r7 <= `RST_SEL;
      s.st <= host_pkg::ST_IDLE;
      s.boot_pend <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign link.req_tgl = s.req_tgl;
  assign link.cmd = s.cmd;
  assign link.wbyte = s.wbyte;
  assign link.mack = s.mack;
  assign link.bypass = s.bypass;

  temp_averager #(.W(12)) ext_avg_u ( // R6 R14
    .clk(clk),
    .reset(reset),
    .mode(s.r2[`C2_TAVG_HI:`C2_TAVG_LO]),
    .is_unsigned(s.r4[`C4_UNS]),
    .in_valid(s.temp_valid),
    .in_data(s.temp_sample),
    .avg_out(ext_avg)
  );

  temp_averager #(.W(12)) onchip_avg_u ( // R9
    .clk(clk),
    .reset(reset),
    .mode(s.r3[`C3_OAVG_HI:`C3_OAVG_LO]),
    .is_unsigned(1'b0),
    .in_valid(onchip_temp_valid),
    .in_data(onchip_temp_in),
    .avg_out(onchip_temp_avg)
  );

  i2c_bit_engine #(.QUARTER(QUARTER)) engine_u (
    .link_clk(link_clk),
    .reset(reset),
    .link(link),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .tgt_scl_i(tgt_scl_i),
    .tgt_sda_i(tgt_sda_i),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  // open-drain: the pins are only ever pulled low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign reg_rdata = s.rdata;
  assign host_busy = s.busy;
endmodule

// ### hw/temp_averager.sv
// running 1/2/4-sample average of a temperature stream
// assumes in_valid is a one-cycle pulse on clk; mode 3 behaves as no average
`timescale 1ns/100ps
module temp_averager #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] mode,
  input wire logic is_unsigned,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic [W-1:0] avg_out
);
  typedef struct packed {
    logic [W-1:0] p0, p1, p2, out;
    logic [1:0] fill;
  } avg_state_t;
  avg_state_t s, n;
  logic [W+1:0] sum2, sum4;

  function automatic logic [W+1:0] ext(input logic [W-1:0] v, input logic u);
    return u ? {2'b00, v} : {{2{v[W-1]}}, v};
  endfunction

  always_comb begin
    n = s;
    sum2 = ext(in_data, is_unsigned) + ext(s.p0, is_unsigned);
    sum4 = sum2 + ext(s.p1, is_unsigned) + ext(s.p2, is_unsigned);
    if (in_valid) begin
      n.p0 = in_data;
      n.p1 = s.p0;
      n.p2 = s.p1;
      if (s.fill != 2'h3) n.fill = s.fill + 2'h1;
      // until enough history exists the newest sample stands alone
      case (mode)
        2'h1: n.out = (s.fill >= 2'h1) ? sum2[W:1] : in_data;
        2'h2: n.out = (s.fill == 2'h3) ? sum4[W+1:2] : in_data;
        default: n.out = in_data;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) s <= '0;
    else s <= n;
  end

  assign avg_out = s.out;
endmodule
